/* File: verilog/err_rec_pkg.sv */
// constants, types and decision functions for the error record block
// assumes one node clock; record state survives anything but power-on reset
package err_rec_pkg;

  // record layout on the register bus
  localparam int          NUM_RECORDS   = 2;
  localparam int          REC_IDX_W     = 1;
  localparam int          REC_SEL_BIT   = 6;
  localparam logic [5:0]  OFF_FEATURE   = 6'h00;
  localparam logic [5:0]  OFF_CONTROL   = 6'h08;
  localparam logic [5:0]  OFF_STATUS    = 6'h10;
  localparam logic [5:0]  OFF_ADDR      = 6'h18;
  localparam logic [5:0]  OFF_EXTRA0    = 6'h20;
  localparam logic [5:0]  OFF_EXTRA1    = 6'h28;

  // status field positions
  localparam int ST_ADDR_HELD = 31;
  localparam int ST_FILLED    = 30;
  localparam int ST_UNCORR    = 29;
  localparam int ST_ABORT     = 28;
  localparam int ST_OVFL      = 27;
  localparam int ST_MISC_HELD = 26;
  localparam int ST_CORR_HI   = 25;
  localparam int ST_CORR_LO   = 24;
  localparam int ST_POSTPONED = 23;
  localparam int ST_POISON    = 22;
  localparam int ST_SUB_HI    = 21;
  localparam int ST_SUB_LO    = 20;
  localparam int ST_IMPL_HI   = 15;
  localparam int ST_IMPL_LO   = 8;
  localparam int ST_SRC_HI    = 7;
  localparam int ST_SRC_LO    = 0;

  // feature and control words
  localparam int          FEAT_OVW_POS     = 12;
  localparam logic        OVW_POLICY       = 1'b1;
  localparam logic [31:0] FEATURE_REC0     = 32'h0000_1001;
  localparam int          CTL_LOG_EN       = 0;
  localparam logic [31:0] CONTROL_RESET    = 32'h0000_0001;
  localparam logic [31:0] CONTROL_WMASK    = 32'h0000_0001;
  localparam logic [31:0] WORD_ZERO        = 32'h0000_0000;

  // corrected counter in the low byte of extra register 0
  localparam int          CNT_HI   = 7;
  localparam logic [7:0]  CNT_MAX  = 8'hFF;
  localparam logic [7:0]  CNT_ONE  = 8'h01;
  localparam logic [1:0]  CORR_MARK = 2'h1;
  localparam logic [1:0]  CORR_NONE = 2'h0;

  // uncorrected subtype codes
  localparam logic [1:0]  SUB_LATENT    = 2'h2;
  localparam logic [1:0]  SUB_SIGNALED  = 2'h3;
  localparam logic [1:0]  SUB_UNRECOV   = 2'h1;
  localparam logic [1:0]  SUB_UNCONT    = 2'h0;

  localparam logic [1:0]  RESP_OKAY   = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;

  // error classes in rising priority
  typedef enum logic [2:0] {
    CLS_NONE     = 3'b000,
    CLS_CORR     = 3'b001,
    CLS_DEFER    = 3'b010,
    CLS_LATENT   = 3'b011,
    CLS_SIGNALED = 3'b100,
    CLS_UNRECOV  = 3'b101,
    CLS_UNCONT   = 3'b110
  } err_class_t;

  typedef enum logic [2:0] {
    ACT_OVERWRITE      = 3'b000,
    ACT_KEEP           = 3'b001,
    ACT_OVERFLOW       = 3'b010,
    ACT_COUNT_KEEP     = 3'b011,
    ACT_COUNT_OVW_KEEP = 3'b100,
    ACT_COUNT_OVW      = 3'b101,
    ACT_OVW_OVFL       = 3'b110
  } act_t;

  // [R05] subtype code of an uncorrected class
  function automatic logic [1:0] sub_of(input err_class_t c);
    unique case (c)
      CLS_LATENT:   sub_of = SUB_LATENT;
      CLS_SIGNALED: sub_of = SUB_SIGNALED;
      CLS_UNRECOV:  sub_of = SUB_UNRECOV;
      default:      sub_of = SUB_UNCONT;
    endcase
  endfunction : sub_of

  // [R05] highest class held by a status word
  function automatic err_class_t class_of(input logic [31:0] s);
    if (!s[ST_FILLED])
      class_of = CLS_NONE;
    else if (s[ST_UNCORR]) begin
      unique case (s[ST_SUB_HI:ST_SUB_LO])
        SUB_LATENT:   class_of = CLS_LATENT;
        SUB_SIGNALED: class_of = CLS_SIGNALED;
        SUB_UNRECOV:  class_of = CLS_UNRECOV;
        default:      class_of = CLS_UNCONT;
      endcase
    end else if (s[ST_POSTPONED])
      class_of = CLS_DEFER;
    else if (s[ST_CORR_HI:ST_CORR_LO] != CORR_NONE)
      class_of = CLS_CORR;
    else
      class_of = CLS_NONE;
  endfunction : class_of

  // [R06] [R07] action from previous and new class
  function automatic act_t choose_action(input err_class_t prev, input err_class_t nw);
    if (nw == CLS_CORR) begin
      if (prev == CLS_NONE)
        choose_action = ACT_COUNT_OVW;
      else if (prev == CLS_CORR)
        choose_action = ACT_COUNT_OVW_KEEP;
      else
        choose_action = ACT_COUNT_KEEP;
    end else if (nw == CLS_DEFER) begin
      if (prev == CLS_NONE || prev == CLS_CORR)
        choose_action = ACT_OVERWRITE;
      else if (prev == CLS_DEFER)
        choose_action = ACT_OVERFLOW;
      else
        choose_action = ACT_KEEP;
    end else begin
      if (prev == CLS_NONE || prev == CLS_CORR || prev == CLS_DEFER)
        choose_action = ACT_OVERWRITE;
      else if (nw > prev)
        choose_action = ACT_OVW_OVFL;
      else
        choose_action = ACT_OVERFLOW;
    end
  endfunction : choose_action

endpackage : err_rec_pkg

/* File: verilog/error_record_update.sv */
// error records of one node: priority update from detectors, AXI4-Lite access
// assumes detectors present at most one error a cycle, synchronous to clk_sys
//
// Contract
// [R01] at least one record, consecutive indices
// [R02] later records: feature zero, control reads zero
// [R03] each new error updates type fields
// [R04] replace syndrome only on strictly higher priority
// [R05] status encodes highest recorded class
// [R06] empty, corrected, deferred previous: action table
// [R07] uncorrected previous: keep, overflow or overwrite
// [R08] keep: old syndrome, overflow unchanged
// [R09] overflow action: keep syndrome, set overflow
// [R10] overwrite: new syndrome, overflow unchanged
// [R11] count and keep; wrap sets overflow
// [R12] policy bit chooses count-keep or overwrite
// [R13] count then overwrite; wrap sets overflow
// [R14] overwrite writes syndrome fields, sets filled
// [R15] overwrite: address and address-held bit
// [R16] overwrite: extra syndrome and misc-held bit
// [R17] keep leaves syndrome, address, subtype alone
// [R18] keep writes no extra data
// [R19] discarded errors still set type flag
// [R20] one error per cycle, highest only
// [R21] one corrected count per cycle
// [R22] every uncorrected class recorded as given
`timescale 1ns/1ns
module error_record_update (
  // clock and reset
  input  wire logic                                clk_sys,
  input  wire logic                                resetn,
  // error detectors
  input  wire logic                                errValid,
  input  wire logic [err_rec_pkg::REC_IDX_W-1:0]   errRecord,
  input  wire err_rec_pkg::err_class_t             errClass,
  input  wire logic                                errAbort,
  input  wire logic                                errPoison,
  input  wire logic [7:0]                          errImpl,
  input  wire logic [7:0]                          errSource,
  input  wire logic                                errAddrValid,
  input  wire logic [31:0]                         errAddr,
  input  wire logic                                errExtraValid,
  input  wire logic [31:0]                         errExtra,
  // axi4-lite write
  input  wire logic [31:0]                         s_axi_awaddr,
  input  wire logic [2:0]                          s_axi_awprot,
  input  wire logic                                s_axi_awvalid,
  output      logic                                s_axi_awready,
  input  wire logic [31:0]                         s_axi_wdata,
  input  wire logic [3:0]                          s_axi_wstrb,
  input  wire logic                                s_axi_wvalid,
  output      logic                                s_axi_wready,
  output      logic [1:0]                          s_axi_bresp,
  output      logic                                s_axi_bvalid,
  input  wire logic                                s_axi_bready,
  // axi4-lite read
  input  wire logic [31:0]                         s_axi_araddr,
  input  wire logic [2:0]                          s_axi_arprot,
  input  wire logic                                s_axi_arvalid,
  output      logic                                s_axi_arready,
  output      logic [31:0]                         s_axi_rdata,
  output      logic [1:0]                          s_axi_rresp,
  output      logic                                s_axi_rvalid,
  input  wire logic                                s_axi_rready
);
  import err_rec_pkg::*;

  logic [1:0]  rstPipe;
  logic        rstn;
  logic        awHeld, wHeld, next_awHeld, next_wHeld;
  logic [31:0] awAddrQ, wDataQ, next_awAddr, next_wData;
  logic [3:0]  wStrbQ, next_wStrb;
  logic        next_awReady, next_wReady, next_bvalid;
  logic [1:0]  next_bresp;
  logic        next_arReady, next_rvalid;
  logic [31:0] next_rdata;
  logic [1:0]  next_rresp;
  logic [31:0] controlQ, next_control;
  logic        wrFire, wrOk, rdOk;
  logic [REC_IDX_W-1:0] wrRec, rdRec;
  logic [5:0]  wrOff, rdOff;
  logic [31:0] wrMask, rdWord;
  logic        logEnable;
  logic [31:0] statusArr [NUM_RECORDS];
  logic [31:0] addrArr   [NUM_RECORDS];
  logic [31:0] extra0Arr [NUM_RECORDS];
  logic [31:0] extra1Arr [NUM_RECORDS];
  logic        hitArr    [NUM_RECORDS];
  logic        ovwArr    [NUM_RECORDS];
  logic        swArr     [NUM_RECORDS];
  act_t        actArr    [NUM_RECORDS];

  // reset release through two flops
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn)
      rstPipe <= 2'h0;
    else
      rstPipe <= {rstPipe[0], 1'b1};
  end
  assign rstn = rstPipe[1];

  // register decode
  // [R01] record index taken from consecutive address blocks
  assign wrRec  = awAddrQ[REC_SEL_BIT +: REC_IDX_W];
  assign wrOff  = awAddrQ[5:0];
  assign rdRec  = s_axi_araddr[REC_SEL_BIT +: REC_IDX_W];
  assign rdOff  = s_axi_araddr[5:0];
  assign wrFire = awHeld && wHeld && !s_axi_bvalid;
  assign wrMask = {{8{wStrbQ[3]}}, {8{wStrbQ[2]}}, {8{wStrbQ[1]}}, {8{wStrbQ[0]}}};
  assign wrOk   = (awAddrQ[31:REC_SEL_BIT+REC_IDX_W] == '0) && (wrOff inside
                  {OFF_FEATURE, OFF_CONTROL, OFF_STATUS, OFF_ADDR, OFF_EXTRA0, OFF_EXTRA1});
  assign rdOk   = (s_axi_araddr[31:REC_SEL_BIT+REC_IDX_W] == '0) && (rdOff inside
                  {OFF_FEATURE, OFF_CONTROL, OFF_STATUS, OFF_ADDR, OFF_EXTRA0, OFF_EXTRA1});
  assign logEnable = controlQ[CTL_LOG_EN];

  // [R02] only the first record shows feature and control
  always_comb begin
    rdWord = WORD_ZERO;
    unique case (rdOff)
      OFF_FEATURE: rdWord = (rdRec == '0) ? FEATURE_REC0 : WORD_ZERO;
      OFF_CONTROL: rdWord = (rdRec == '0) ? controlQ : WORD_ZERO;
      OFF_STATUS:  rdWord = statusArr[rdRec];
      OFF_ADDR:    rdWord = addrArr[rdRec];
      OFF_EXTRA0:  rdWord = extra0Arr[rdRec];
      OFF_EXTRA1:  rdWord = extra1Arr[rdRec];
      default:     rdWord = WORD_ZERO;
    endcase
  end

  // bus channel next values
  always_comb begin
    next_awHeld  = awHeld;
    next_awAddr  = awAddrQ;
    next_wHeld   = wHeld;
    next_wData   = wDataQ;
    next_wStrb   = wStrbQ;
    next_bvalid  = s_axi_bvalid;
    next_bresp   = s_axi_bresp;
    next_rvalid  = s_axi_rvalid;
    next_rdata   = s_axi_rdata;
    next_rresp   = s_axi_rresp;
    next_control = controlQ;
    if (s_axi_awvalid && s_axi_awready) begin
      next_awHeld = 1'b1;
      next_awAddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      next_wHeld = 1'b1;
      next_wData = s_axi_wdata;
      next_wStrb = s_axi_wstrb;
    end
    if (s_axi_bvalid && s_axi_bready)
      next_bvalid = 1'b0;
    if (wrFire) begin
      next_awHeld = 1'b0;
      next_wHeld  = 1'b0;
      next_bvalid = 1'b1;
      next_bresp  = wrOk ? RESP_OKAY : RESP_SLVERR;
      if (wrOk && wrRec == '0 && wrOff == OFF_CONTROL)
        next_control = (controlQ & ~(wrMask & CONTROL_WMASK)) | (wDataQ & wrMask & CONTROL_WMASK);
    end
    if (s_axi_rvalid && s_axi_rready)
      next_rvalid = 1'b0;
    if (s_axi_arvalid && s_axi_arready) begin
      next_rvalid = 1'b1;
      next_rdata  = rdOk ? rdWord : WORD_ZERO;
      next_rresp  = rdOk ? RESP_OKAY : RESP_SLVERR;
    end
    next_awReady = !next_awHeld && !next_bvalid;
    next_wReady  = !next_wHeld && !next_bvalid;
    next_arReady = !next_rvalid;
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      awHeld        <= 1'b0;
      awAddrQ       <= WORD_ZERO;
      wHeld         <= 1'b0;
      wDataQ        <= WORD_ZERO;
      wStrbQ        <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= RESP_OKAY;
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= WORD_ZERO;
      s_axi_rresp   <= RESP_OKAY;
      controlQ      <= CONTROL_RESET;
    end else begin
      awHeld        <= next_awHeld;
      awAddrQ       <= next_awAddr;
      wHeld         <= next_wHeld;
      wDataQ        <= next_wData;
      wStrbQ        <= next_wStrb;
      s_axi_awready <= next_awReady;
      s_axi_wready  <= next_wReady;
      s_axi_bvalid  <= next_bvalid;
      s_axi_bresp   <= next_bresp;
      s_axi_arready <= next_arReady;
      s_axi_rvalid  <= next_rvalid;
      s_axi_rdata   <= next_rdata;
      s_axi_rresp   <= next_rresp;
      controlQ      <= next_control;
    end
  end

  // one record per pass
  for (genvar r = 0; r < NUM_RECORDS; r++) begin : g_rec
    logic [31:0] stat, addrR, ex0, ex1;
    logic [31:0] next_stat, next_addr, next_ex0, next_ex1;
    err_class_t  prevCls;
    act_t        act;
    logic        hit, ovw, counting, cntWrap, swStat;

    // [R20] a single detector port: one error per cycle
    assign hit    = errValid && (errRecord == REC_IDX_W'(r)) && logEnable;
    assign swStat = wrFire && wrOk && wrRec == REC_IDX_W'(r) && wrOff == OFF_STATUS;

    always_comb begin
      next_stat = stat;
      next_addr = addrR;
      next_ex0  = ex0;
      next_ex1  = ex1;
      // software clears every status byte whose strobe is set, whatever the write data
      if (swStat)
        next_stat = stat & ~wrMask;
      if (wrFire && wrOk && wrRec == REC_IDX_W'(r)) begin
        if (wrOff == OFF_ADDR)
          next_addr = (addrR & ~wrMask) | (wDataQ & wrMask);
        if (wrOff == OFF_EXTRA0)
          next_ex0 = (ex0 & ~wrMask) | (wDataQ & wrMask);
        if (wrOff == OFF_EXTRA1)
          next_ex1 = (ex1 & ~wrMask) | (wDataQ & wrMask);
      end
      // hardware update after software, so a new error wins
      prevCls  = class_of(next_stat);
      act      = choose_action(prevCls, errClass);
      counting = act inside {ACT_COUNT_KEEP, ACT_COUNT_OVW_KEEP, ACT_COUNT_OVW};
      cntWrap  = counting && (next_ex0[CNT_HI:0] == CNT_MAX);
      // [R04] [R12] overwrite for strictly higher priority, or for an equal corrected class when OVW_POLICY is set and overflow is clear
      ovw      = act inside {ACT_OVERWRITE, ACT_COUNT_OVW, ACT_OVW_OVFL} ||
                 (act == ACT_COUNT_OVW_KEEP && OVW_POLICY && !next_stat[ST_OVFL]);
      if (hit) begin
        // [R21] one count per cycle
        if (counting)
          next_ex0[CNT_HI:0] = next_ex0[CNT_HI:0] + CNT_ONE;
        // [R08] [R10] keep and overwrite leave overflow alone
        unique case (act)
          // [R09] overflow action
          ACT_OVERFLOW:       next_stat[ST_OVFL] = 1'b1;
          ACT_OVW_OVFL:       next_stat[ST_OVFL] = 1'b1;
          // [R11] count and keep
          ACT_COUNT_KEEP:     next_stat[ST_OVFL] = next_stat[ST_OVFL] | cntWrap;
          // [R12] count, overwrite or keep
          ACT_COUNT_OVW_KEEP: next_stat[ST_OVFL] = next_stat[ST_OVFL] | cntWrap;
          // [R13] count then overwrite
          ACT_COUNT_OVW:      next_stat[ST_OVFL] = next_stat[ST_OVFL] | cntWrap;
          default:            next_stat[ST_OVFL] = next_stat[ST_OVFL];
        endcase
        // [R03] [R19] type flag set even when discarded
        unique case (errClass)
          CLS_CORR: begin
            if (next_stat[ST_CORR_HI:ST_CORR_LO] == CORR_NONE || !next_stat[ST_FILLED])
              next_stat[ST_CORR_HI:ST_CORR_LO] = CORR_MARK;
            if (ovw) begin
              next_stat[ST_POSTPONED] = 1'b0;
              next_stat[ST_UNCORR]    = 1'b0;
            end
          end
          CLS_DEFER: begin
            next_stat[ST_POSTPONED] = 1'b1;
            if (ovw)
              next_stat[ST_UNCORR] = 1'b0;
            if (!next_stat[ST_FILLED])
              next_stat[ST_CORR_HI:ST_CORR_LO] = CORR_NONE;
          end
          default: begin
            next_stat[ST_UNCORR] = 1'b1;
            // [R17] [R22] subtype kept unless overwriting; class stored as given
            if (ovw)
              next_stat[ST_SUB_HI:ST_SUB_LO] = sub_of(errClass);
          end
        endcase
        // [R14] overwrite takes the new syndrome
        if (ovw) begin
          next_stat[ST_ABORT]              = errAbort;
          next_stat[ST_POISON]             = errPoison;
          next_stat[ST_IMPL_HI:ST_IMPL_LO] = errImpl;
          next_stat[ST_SRC_HI:ST_SRC_LO]   = errSource;
          next_stat[ST_FILLED]             = 1'b1;
          // [R15] address and its held bit
          next_stat[ST_ADDR_HELD] = errAddrValid;
          if (errAddrValid)
            next_addr = errAddr;
          // [R16] extra syndrome and its held bit
          next_stat[ST_MISC_HELD] = errExtraValid;
          if (errExtraValid)
            next_ex1 = errExtra;
        end
        // [R18] a kept error writes nothing into extra register 1; only the corrected count in extra register 0 moves
      end
    end

    always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
        stat  <= WORD_ZERO;
        addrR <= WORD_ZERO;
        ex0   <= WORD_ZERO;
        ex1   <= WORD_ZERO;
      end else begin
        stat  <= next_stat;
        addrR <= next_addr;
        ex0   <= next_ex0;
        ex1   <= next_ex1;
      end
    end

    assign statusArr[r] = stat;
    assign addrArr[r]   = addrR;
    assign extra0Arr[r] = ex0;
    assign extra1Arr[r] = ex1;
    assign hitArr[r]    = hit;
    assign ovwArr[r]    = ovw;
    assign actArr[r]    = act;
    assign swArr[r]     = wrFire && wrOk && wrRec == REC_IDX_W'(r);
  end

  // checks on record 0 and on the read channel
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn);

  sequence s_empty_latent;
    hitArr[0] && !swArr[0] && !statusArr[0][ST_FILLED] && errClass == CLS_LATENT;
  endsequence
  sequence s_then_uncont;
    hitArr[0] && !swArr[0] && errClass == CLS_UNCONT;
  endsequence

  a_overwrite_fields: assert property (hitArr[0] && ovwArr[0] |=> statusArr[0][ST_FILLED] && // [R14]
      statusArr[0][ST_IMPL_HI:ST_IMPL_LO] == $past(errImpl) && statusArr[0][ST_POISON] == $past(errPoison))
    else $error("overwrite did not store syndrome");
  a_keep_syndrome: assert property (hitArr[0] && !ovwArr[0] && !swArr[0] |=> // [R17]
      $stable(statusArr[0][ST_IMPL_HI:ST_IMPL_LO]) && $stable(addrArr[0]) && $stable(statusArr[0][ST_ADDR_HELD]))
    else $error("kept record changed syndrome");
  a_overflow_set: assert property (hitArr[0] && actArr[0] == ACT_OVERFLOW |=> statusArr[0][ST_OVFL]) // [R09]
    else $error("overflow action did not set overflow");
  a_addr_held: assert property (hitArr[0] && ovwArr[0] && errAddrValid |=> // [R15]
      statusArr[0][ST_ADDR_HELD] && addrArr[0] == $past(errAddr))
    else $error("address not recorded");
  a_misc_held: assert property (hitArr[0] && ovwArr[0] |=> // [R16]
      statusArr[0][ST_MISC_HELD] == $past(errExtraValid))
    else $error("misc held bit wrong");
  a_defer_flag: assert property (hitArr[0] && errClass == CLS_DEFER |=> statusArr[0][ST_POSTPONED]) // [R19]
    else $error("deferred flag not set");
  a_subtype_code: assert property (hitArr[0] && ovwArr[0] && errClass > CLS_DEFER |=> // [R05]
      statusArr[0][ST_UNCORR] && statusArr[0][ST_SUB_HI:ST_SUB_LO] == sub_of($past(errClass)))
    else $error("subtype code wrong");
  a_corr_count: assert property (hitArr[0] && errClass == CLS_CORR && !swArr[0] |=> // [R21]
      extra0Arr[0][CNT_HI:0] == 8'($past(extra0Arr[0][CNT_HI:0]) + CNT_ONE))
    else $error("corrected error not counted");
  a_higher_replace: assert property (s_empty_latent ##[2:4] s_then_uncont |=> // [R07]
      statusArr[0][ST_OVFL] && statusArr[0][ST_SUB_HI:ST_SUB_LO] == SUB_UNCONT)
    else $error("higher class did not overwrite with overflow");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid) // every accepted read answered
    else $error("read not answered");

endmodule : error_record_update

/* File: testbench/err_source.sv */
// error detector model: one error pulse per send call
// assumes the bench calls send and shares clk_sys
`timescale 1ns/1ns
module err_source (
  // clock
  input  wire logic                              clk_sys,
  // error port
  output      logic                              errValid,
  output      logic [err_rec_pkg::REC_IDX_W-1:0] errRecord,
  output      err_rec_pkg::err_class_t           errClass,
  output      logic                              errAbort,
  output      logic                              errPoison,
  output      logic [7:0]                        errImpl,
  output      logic [7:0]                        errSource,
  output      logic                              errAddrValid,
  output      logic [31:0]                       errAddr,
  output      logic                              errExtraValid,
  output      logic [31:0]                       errExtra
);
  import err_rec_pkg::*;
  initial begin
    errValid = 1'b0;
    errRecord = '0;
    errClass = CLS_CORR;
    {errAbort, errPoison, errAddrValid, errExtraValid} = 4'h0;
    {errImpl, errSource, errAddr, errExtra} = '0;
  end
  task automatic send(input int g, input int r, input err_class_t c, input logic [3:0] f,
                      input logic [31:0] a, input logic [31:0] x, input logic [7:0] m);
    // idle edge first, so back-to-back calls never drive errValid twice in one step
    repeat (g + 1) @(posedge clk_sys);
    errValid <= 1'b1;
    errRecord <= r[REC_IDX_W-1:0];
    errClass <= c;
    {errAbort, errPoison, errAddrValid, errExtraValid} <= f;
    {errImpl, errSource, errAddr, errExtra} <= {m, ~m, a, x};
    @(posedge clk_sys);
    errValid <= 1'b0;
    // released lines show the inverse, not the old value
    {errImpl, errSource, errAddr, errExtra} <= {~m, m, ~a, ~x};
  endtask : send
endmodule : err_source

/* File: testbench/error_record_update_tb.sv */
// bench: axi4-lite master, record model, random errors
// assumes err_source drives the error port
`timescale 1ns/1ns
module error_record_update_tb;
  import err_rec_pkg::*;
  logic                 clk_sys, resetn, errValid, errAbort, errPoison, errAddrValid, errExtraValid, logEn;
  logic [REC_IDX_W-1:0] errRecord;
  err_class_t           errClass;
  logic [7:0]           errImpl, errSource;
  logic [31:0]          errAddr, errExtra, s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata, d;
  logic                 s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic                 s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [1:0]           s_axi_bresp, s_axi_rresp, rs;
  logic [31:0]          expSt [NUM_RECORDS], expAdr [NUM_RECORDS], expCnt [NUM_RECORDS], expX1 [NUM_RECORDS];
  int                   miscompares, checks, seed;
  error_record_update DUT (.clk_sys, .resetn, .errValid, .errRecord, .errClass, .errAbort, .errPoison,
    .errImpl, .errSource, .errAddrValid, .errAddr, .errExtraValid, .errExtra, .s_axi_awaddr,
    .s_axi_awprot(3'h0), .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hF), .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arprot(3'h0),
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
  err_source src (.clk_sys, .errValid, .errRecord, .errClass, .errAbort, .errPoison, .errImpl,
    .errSource, .errAddrValid, .errAddr, .errExtraValid, .errExtra);
  initial begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end
  task automatic finish_test;
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : finish_test
  task automatic cmp(input string n, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      miscompares++;
      $display("unexpected %s expected %h seen %h", n, e, g);
    end
  endtask : cmp
  task automatic axi(input logic wr, input logic [31:0] a, input logic [31:0] v);
    int n;
    n = 0;
    @(posedge clk_sys);
    {s_axi_awaddr, s_axi_wdata, s_axi_araddr} <= {a, v, a};
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= {3{wr}};
    {s_axi_arvalid, s_axi_rready} <= {2{!wr}};
    do begin
      @(posedge clk_sys);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      n++;
    end while (!(wr ? s_axi_bvalid : s_axi_rvalid) && n < 200);
    rs = wr ? s_axi_bresp : s_axi_rresp;
    d = s_axi_rdata;
    {s_axi_bready, s_axi_rready} <= 2'h0;
    if (n >= 200) begin
      miscompares++;
      finish_test();
    end
  endtask : axi
  task automatic chk_rec(input int r);
    logic [31:0] b;
    b = 32'(r) << REC_SEL_BIT;
    axi(1'b0, b + 32'(OFF_STATUS), 32'h0);
    cmp("status", expSt[r], d);
    axi(1'b0, b + 32'(OFF_ADDR), 32'h0);
    cmp("address", expAdr[r], d);
    axi(1'b0, b + 32'(OFF_EXTRA0), 32'h0);
    cmp("counter", expCnt[r], d);
    axi(1'b0, b + 32'(OFF_EXTRA1), 32'h0);
    cmp("extra", expX1[r], d);
  endtask : chk_rec
  task automatic clr(input int r);
    axi(1'b1, (32'(r) << REC_SEL_BIT) + 32'(OFF_STATUS), 32'hFFFF_FFFF);
    axi(1'b1, (32'(r) << REC_SEL_BIT) + 32'(OFF_EXTRA0), 32'h0000_00FE);
    expSt[r] = 32'h0;
    expCnt[r] = 32'h0000_00FE;
  endtask : clr
  task automatic inject(input int r, input err_class_t c);
    logic [31:0] s, a, x;
    logic [3:0]  f;
    logic [7:0]  m;
    logic        ow, ov;
    int          p;
    s = expSt[r];
    {a, x, f, m} = {$random(seed), $random(seed), 4'($random(seed)), 8'($random(seed))};
    p = !s[30] ? 0 : s[29] ? (s[21:20] == 2'h2 ? 3 : s[21:20] == 2'h3 ? 4 : s[21:20] == 2'h1 ? 5 : 6) :
        s[23] ? 2 : int'(s[25:24] != 2'h0);
    if (c == CLS_CORR) begin
      {ow, ov} = {p == 0 || (p == 1 && !s[27]), expCnt[r][7:0] == 8'hFF};
      if (logEn) expCnt[r][7:0] = expCnt[r][7:0] + 8'h01;
      if (s[25:24] == 2'h0) s[25:24] = 2'h1;
    end else if (c == CLS_DEFER) begin
      {ow, ov, s[23]} = {p < 2, p == 2, 1'b1};
    end else begin
      {ow, ov, s[29]} = {p < 3 || int'(c) > p, p > 2, 1'b1};
      if (ow) s[21:20] = c == CLS_LATENT ? 2'h2 : c == CLS_SIGNALED ? 2'h3 : c == CLS_UNRECOV ? 2'h1 : 2'h0;
    end
    if (ov) s[27] = 1'b1;
    if (ow) begin
      {s[31], s[30], s[28], s[26], s[22], s[15:0]} = {f[1], 1'b1, f[3], f[0], f[2], m, ~m};
      if (f[1] && logEn) expAdr[r] = a;
      if (f[0] && logEn) expX1[r] = x;
    end
    if (logEn) expSt[r] = s;
    src.send($unsigned($random(seed)) % 3, r, c, f, a, x, m);
  endtask : inject
  initial begin
    {seed, miscompares, checks, logEn, resetn} = {32'd62, 32'd0, 32'd0, 1'b1, 1'b0};
    {s_axi_awaddr, s_axi_wdata, s_axi_araddr} = '0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h0;
    foreach (expSt[i]) {expSt[i], expAdr[i], expCnt[i], expX1[i]} = '0;
    repeat (5) @(posedge clk_sys);
    resetn <= 1'b1;
    for (int r = 0; r < NUM_RECORDS; r++) chk_rec(r);
    axi(1'b0, 32'h0, 32'h0);
    cmp("feature0", 32'h0000_1001, d);
    axi(1'b1, 32'h48, 32'h1);
    axi(1'b0, 32'h48, 32'h0);
    cmp("control1", 32'h0, d);
    axi(1'b0, 32'h40, 32'h0);
    cmp("feature1", 32'h0, d);
    axi(1'b0, 32'h30, 32'h0);
    cmp("rresp", 32'h2, 32'(rs));
    axi(1'b1, 32'h100, 32'h1);
    cmp("bresp", 32'h2, 32'(rs));
    $display("test identity done");
    for (int p = 0; p < 7; p++)
      for (int n = 1; n < 7; n++) begin
        clr(0);
        if (p > 0) inject(0, err_class_t'(p));
        inject(0, err_class_t'(n));
        chk_rec(0);
      end
    $display("test priority table done");
    for (int i = 0; i < 90; i++) begin
      automatic int r = $unsigned($random(seed)) % NUM_RECORDS;
      if (i % 12 == 0) clr(r);
      inject(r, err_class_t'(1 + $unsigned($random(seed)) % 6));
      if (i % 3 != 0) chk_rec(r);
    end
    $display("test random errors done");
    clr(0);
    axi(1'b1, 32'(OFF_CONTROL), 32'h0);
    logEn = 1'b0;
    inject(0, CLS_UNCONT);
    chk_rec(0);
    logEn = 1'b1;
    axi(1'b1, 32'(OFF_CONTROL), 32'h1);
    $display("test logging off done");
    finish_test();
  end
endmodule : error_record_update_tb
